// [rtl/uart_irq_flow_trigger_ctrl.sv]
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "uart_ctrl_consts.svh"
module uart_irq_flow_trigger_ctrl (
    // APB slave
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [11:0]             paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    // Datapath events and status
    input  wire uart_ctrl_pkg::irq_src_t src_events,
    input  wire uart_ctrl_pkg::fifo_stat_t fifo_stat,
    input  wire logic                    rx_char_valid,
    input  wire logic [7:0]              rx_char,
    // Modem pins, active low
    input  wire logic                    cts_n,
    output logic                         rts_n,
    // Controls to datapath
    output logic                         tx_allow,
    output logic [15:0]                  baud_divisor,
    output logic [3:0]                   sw_flow_mode,
    output logic [6:0]                   rx_trigger,
    output logic [6:0]                   tx_trigger,
    output logic                         rx_trig_from_fcr,
    output logic                         tx_trig_from_fcr,
    output logic                         irq
);
    logic [7:0] ier_r, fcr_r, mcr_r, efr_r, dll_r, dlh_r, tcr_r, tlr_r, xchar_r;
    uart_ctrl_pkg::irq_src_t pend_r;
    logic [5:0] iid_nxt;
    logic       wr, rd, enh, trig_acc;
    logic [7:0] wdat;
    logic [6:0] halt_lvl, resume_lvl, tx_space;
    logic       special_hit;
    logic [7:0] rdat_nxt;
    logic       mapped;

    assign wr       = psel && penable && pwrite && pready;
    assign rd       = psel && !penable && !pwrite;
    assign wdat     = pwdata[7:0];
    assign enh      = efr_r[`EFR_ENH_EN];
    assign trig_acc = enh && mcr_r[`MCR_TRIG_EN];
    assign special_hit = efr_r[`EFR_SPECIAL_EN] && rx_char_valid
                         && (rx_char == xchar_r);

    // Zero-wait APB: ready is held high after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= 1'b1;
        end
    end

    // Plain control registers; protected bits keep old value without enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ier_r   <= `RESET_BYTE;
            fcr_r   <= `RESET_BYTE;
            mcr_r   <= `RESET_BYTE;
            efr_r   <= `RESET_BYTE;
            xchar_r <= `RESET_BYTE;
        end else if (wr) begin
            case (paddr)
                `OFS_INT_ENABLE:
                    ier_r <= enh ? wdat : ((ier_r & `IER_PROT_MASK)
                             | (wdat & ~`IER_PROT_MASK));
                `OFS_FIFO_CONTROL:
                    fcr_r <= enh ? wdat : ((fcr_r & `FCR_PROT_MASK)
                             | (wdat & ~`FCR_PROT_MASK));
                `OFS_MODEM_CONTROL:
                    // Bit 2 is a gate too, so it shares the enhanced lock
                    mcr_r <= enh ? wdat : ((mcr_r & (`MCR_PROT_MASK | 8'h04))
                             | (wdat & ~(`MCR_PROT_MASK | 8'h04)));
                `OFS_ENH_FEATURES:  efr_r   <= wdat;
                `OFS_SPECIAL_CHAR:  xchar_r <= wdat;
                default: ;
            endcase
        end
    end

    // Divisor bytes, frozen once sleep is enabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dll_r <= `RESET_BYTE;
            dlh_r <= `RESET_BYTE;
        end else if (wr && !ier_r[`IER_SLEEP]) begin
            if (paddr == `OFS_DIV_LOW)
                dll_r <= wdat;
            if (paddr == `OFS_DIV_HIGH)
                dlh_r <= wdat;
        end
    end

    // Threshold and trigger registers behind the double gate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tcr_r <= `RESET_BYTE;
            tlr_r <= `RESET_BYTE;
        end else if (wr && trig_acc) begin
            if (paddr == `OFS_FLOW_THRESH)
                tcr_r <= wdat;
            if (paddr == `OFS_TRIG_LEVEL)
                tlr_r <= wdat;
        end
    end

    // Sticky pending sources; a set in the clear cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_r <= '0;
        end else begin
            uart_ctrl_pkg::irq_src_t clr;
            uart_ctrl_pkg::irq_src_t setv;
            clr  = (wr && paddr == `OFS_SRC_CLEAR) ? uart_ctrl_pkg::irq_src_t'(pwdata[6:0])
                                                   : '0;
            setv = src_events;
            setv.special = src_events.special | special_hit;
            pend_r <= (pend_r & ~clr) | setv;
        end
    end

    // Priority encode of enabled sources, and of modem, which has no enable
    always_comb begin
        iid_nxt = `IID_NONE;
        if (pend_r.flow_change && (ier_r[7] || ier_r[6]))
            iid_nxt = `IID_FLOW_CHANGE;
        if (pend_r.special && (ier_r[5] || efr_r[`EFR_SPECIAL_EN]))
            iid_nxt = `IID_SPECIAL;
        if (pend_r.modem)
            iid_nxt = `IID_MODEM;
        if (pend_r.tx_hold && ier_r[1])
            iid_nxt = `IID_TX_HOLD;
        if (pend_r.rx_data && ier_r[0])
            iid_nxt = `IID_RX_DATA;
        if (pend_r.rx_timeout && ier_r[0])
            iid_nxt = `IID_RX_TIMEOUT;
        if (pend_r.line_err && ier_r[2])
            iid_nxt = `IID_LINE_ERR;
    end

    // Threshold levels in characters, field times four
    assign halt_lvl   = {1'b0, tcr_r[3:0], 2'b00};
    assign resume_lvl = {1'b0, tcr_r[7:4], 2'b00};
    assign tx_space   = `FIFO_DEPTH - fifo_stat.tx_level;

    // Flow control pins and derived control outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rts_n            <= 1'b1;
            tx_allow         <= 1'b1;
            baud_divisor     <= 16'h0000;
            sw_flow_mode     <= 4'h0;
            rx_trigger       <= 7'h00;
            tx_trigger       <= 7'h00;
            rx_trig_from_fcr <= 1'b1;
            tx_trig_from_fcr <= 1'b1;
            irq              <= 1'b0;
        end else begin
            if (efr_r[`EFR_RTS_EN]) begin
                if (fifo_stat.rx_level >= halt_lvl)
                    rts_n <= 1'b1;
                else if (fifo_stat.rx_level <= resume_lvl)
                    rts_n <= 1'b0;
            end else begin
                rts_n <= !mcr_r[`MCR_RTS_FORCE];
            end
            tx_allow     <= !(efr_r[`EFR_CTS_EN] && cts_n);
            baud_divisor <= {dlh_r, dll_r};
            sw_flow_mode <= efr_r[3:0];
            rx_trigger   <= {1'b0, tlr_r[7:4], 2'b00};
            tx_trigger   <= {1'b0, tlr_r[3:0], 2'b00};
            rx_trig_from_fcr <= (tlr_r[7:4] == 4'h0);
            tx_trig_from_fcr <= (tlr_r[3:0] == 4'h0);
            irq          <= !iid_nxt[0];
        end
    end

    // Read mux, answered in the access cycle
    always_comb begin
        mapped   = 1'b1;
        rdat_nxt = 8'h00;
        case (paddr)
            `OFS_INT_ENABLE:    rdat_nxt = ier_r;
            `OFS_INT_IDENT:     rdat_nxt = {{2{fcr_r[`FCR_FIFO_EN]}}, iid_nxt};
            `OFS_FIFO_CONTROL:  rdat_nxt = fcr_r;
            `OFS_MODEM_CONTROL: rdat_nxt = mcr_r;
            `OFS_ENH_FEATURES:  rdat_nxt = efr_r;
            `OFS_DIV_LOW:       rdat_nxt = dll_r;
            `OFS_DIV_HIGH:      rdat_nxt = dlh_r;
            `OFS_FLOW_THRESH:   rdat_nxt = trig_acc ? tcr_r : 8'h00;
            `OFS_TRIG_LEVEL:    rdat_nxt = trig_acc ? tlr_r : 8'h00;
            `OFS_TX_SPACE:      rdat_nxt = {1'b0, tx_space};
            `OFS_SPECIAL_CHAR:  rdat_nxt = xchar_r;
            `OFS_STATUS:        rdat_nxt = {1'b0, pend_r};
            `OFS_SRC_CLEAR:     rdat_nxt = 8'h00;
            default:            mapped   = 1'b0;
        endcase
    end

    // Read data and error latched at setup, stable through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata  <= rd ? {24'h000000, rdat_nxt} : 32'h0000_0000;
            pslverr <= !mapped;
        end
    end
endmodule

// [shared/uart_ctrl_consts.svh]
`ifndef UART_CTRL_CONSTS_SVH
`define UART_CTRL_CONSTS_SVH
// Register byte offsets on APB
`define OFS_INT_ENABLE    12'h000
`define OFS_INT_IDENT     12'h004
`define OFS_FIFO_CONTROL  12'h008
`define OFS_MODEM_CONTROL 12'h00c
`define OFS_ENH_FEATURES  12'h010
`define OFS_DIV_LOW       12'h014
`define OFS_DIV_HIGH      12'h018
`define OFS_FLOW_THRESH   12'h01c
`define OFS_TRIG_LEVEL    12'h020
`define OFS_TX_SPACE      12'h024
`define OFS_SPECIAL_CHAR  12'h028
`define OFS_STATUS        12'h02c
`define OFS_SRC_CLEAR     12'h030
// Interrupt source codes, bits 5:0
`define IID_LINE_ERR      6'h06
`define IID_RX_TIMEOUT    6'h0c
`define IID_RX_DATA       6'h04
`define IID_TX_HOLD       6'h02
`define IID_MODEM         6'h00
`define IID_SPECIAL       6'h10
`define IID_FLOW_CHANGE   6'h20
`define IID_NONE          6'h01
// Field bits
`define EFR_CTS_EN        7
`define EFR_RTS_EN        6
`define EFR_SPECIAL_EN    5
`define EFR_ENH_EN        4
`define IER_SLEEP         4
`define MCR_TRIG_EN       2
`define MCR_RTS_FORCE     1
`define FCR_FIFO_EN       0
`define RESET_BYTE        8'h00
`define FIFO_DEPTH        7'h40
`define LEVEL_SHIFT       2
`define IER_PROT_MASK     8'hf0
`define FCR_PROT_MASK     8'h30
`define MCR_PROT_MASK     8'he0
`endif

// [shared/uart_ctrl_pkg.sv]
package uart_ctrl_pkg;
    // Pending interrupt sources, one bit each
    typedef struct packed {
        logic line_err;
        logic rx_timeout;
        logic rx_data;
        logic tx_hold;
        logic modem;
        logic special;
        logic flow_change;
    } irq_src_t;
    // Datapath status from FIFOs
    typedef struct packed {
        logic [6:0] rx_level;
        logic [6:0] tx_level;
    } fifo_stat_t;
endpackage

// [dv/uart_ctrl_properties.sv]
`timescale 1ns/1ps
module uart_ctrl_properties (
    // Clock, reset and bus
    input wire logic                     pclk,
    input wire logic                     presetn,
    input wire logic                     psel,
    input wire logic                     penable,
    input wire logic                     pwrite,
    input wire logic [11:0]              paddr,
    input wire logic                     pready,
    // Events and controls
    input wire uart_ctrl_pkg::irq_src_t  src_events,
    input wire logic                     rx_char_valid,
    input wire logic                     cts_n,
    input wire logic                     tx_allow,
    input wire logic [15:0]              baud_divisor,
    input wire logic [3:0]               sw_flow_mode,
    input wire logic [6:0]               rx_trigger,
    input wire logic [6:0]               tx_trigger,
    input wire logic                     rx_trig_from_fcr,
    input wire logic                     irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Completed writes by target; two cycles allowed for output staging
    logic wr, w_div, w_efr, w_trg, cause;
    assign wr = psel && penable && pwrite && pready;
    assign w_div = wr && (paddr == 12'h014 || paddr == 12'h018);
    assign w_efr = wr && paddr == 12'h010;
    assign w_trg = wr && paddr == 12'h020;
    assign cause = src_events != '0 || rx_char_valid || wr;
    a_cts_halt_tx: assert property (!tx_allow |-> $past(cts_n))
        else $error("transmit held without cts_n high");
    a_div_by_write: assert property ($changed(baud_divisor) |-> $past(w_div) || $past(w_div, 2))
        else $error("divisor changed without a write");
    a_div_one_byte: assert property ($changed(baud_divisor)
        |-> $stable(baud_divisor[15:8]) || $stable(baud_divisor[7:0]))
        else $error("both divisor bytes changed at once");
    a_flow_mode_write: assert property ($changed(sw_flow_mode) |-> $past(w_efr) || $past(w_efr, 2))
        else $error("flow mode changed without a write");
    a_trig_by_write: assert property ($changed({rx_trigger, tx_trigger})
        |-> $past(w_trg) || $past(w_trg, 2))
        else $error("trigger changed without a write");
    a_trig_step_four: assert property (rx_trigger[1:0] == 2'h0 && tx_trigger[1:0] == 2'h0)
        else $error("trigger not a multiple of four");
    a_rx_fcr_select: assert property (rx_trig_from_fcr == (rx_trigger == 7'h00))
        else $error("rx trigger source wrong");
    a_irq_has_cause: assert property ($rose(irq) |-> $past(cause) || $past(cause, 2))
        else $error("interrupt rose without a cause");
    cover property ($rose(irq));
    cover property (!tx_allow);
    cover property ($changed(rx_trigger));
endmodule

bind uart_irq_flow_trigger_ctrl uart_ctrl_properties u_uart_ctrl_properties (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pready, .src_events, .rx_char_valid, .cts_n, .tx_allow,
    .baud_divisor, .sw_flow_mode, .rx_trigger, .tx_trigger, .rx_trig_from_fcr, .irq);

// [dv/remote_uart_model.sv]
`timescale 1ns/1ps
module remote_uart_model (
    // Clock and reset
    input wire logic       pclk,
    input wire logic       presetn,
    // Bench controls
    input wire logic       fill,
    input wire logic       drain,
    input wire logic       cts_req_n,
    // Link pins and receive level
    input wire logic       rts_n,
    output logic           cts_n,
    output logic     [6:0] rx_level
);
    // Clear-to-send is a plain level from the remote side
    assign cts_n = cts_req_n;
    // Sender pauses while rts_n is high, so the level cannot run away
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_level <= 7'h00;
        end else if (fill && !rts_n && rx_level < 7'h40) begin
            rx_level <= rx_level + 7'h01;
        end else if (drain && rx_level != 7'h00) begin
            rx_level <= rx_level - 7'h01;
        end
    end
endmodule

// [dv/uart_irq_flow_trigger_ctrl_tb_top.sv]
`timescale 1ns/1ps
module uart_irq_flow_trigger_ctrl_tb_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic pready, pslverr, rx_char_valid = 0, cts_req_n = 0, fill = 0, drain = 0;
    logic [7:0] rx_char = '0, q;
    logic cts_n, rts_n, tx_allow, rx_fcr, tx_fcr, irq, e;
    logic [15:0] baud;
    logic [3:0] sw_flow_mode;
    logic [6:0] rx_trigger, tx_trigger, rx_level;
    uart_ctrl_pkg::irq_src_t src_events = '0;
    int error_cnt = 0, comparisons = 0;
    // Source codes in priority order
    logic [5:0] codes [7] = '{6'h06, 6'h0c, 6'h04, 6'h02, 6'h00, 6'h10, 6'h20};

    always #2.5 pclk = ~pclk;

    uart_irq_flow_trigger_ctrl u_uart_irq_flow_trigger_ctrl (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .src_events,
        .fifo_stat({rx_level, 7'h40}), .rx_char_valid, .rx_char, .cts_n, .rts_n, .tx_allow,
        .baud_divisor(baud), .sw_flow_mode, .rx_trigger, .tx_trigger,
        .rx_trig_from_fcr(rx_fcr), .tx_trig_from_fcr(tx_fcr), .irq);
    remote_uart_model u_remote_uart_model (.pclk, .presetn, .fill, .drain, .cts_req_n, .rts_n,
        .cts_n, .rx_level);

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; waits for pready with a bound
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n == 20) error_cnt++;
        q = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rc(input logic [11:0] a, input logic [7:0] x);
        apb(1'b0, a, 8'h00);
        chk(q, x);
    endtask
    task automatic st;
        repeat (3) @(posedge pclk);
        #1;
    endtask
    task automatic wait_rts(input logic v);
        for (int n = 0; n < 300 && rts_n !== v; n++) @(posedge pclk);
        #1;
    endtask

    task automatic t_gate;
        wr(12'h000, 8'hf0);
        rc(12'h000, 8'h00);
        wr(12'h00c, 8'h04);
        wr(12'h020, 8'h53);
        st;
        chk(rx_trigger, 7'h00);
        wr(12'h010, 8'h1f);
        wr(12'h00c, 8'h04);
        wr(12'h020, 8'h53);
        st;
        chk(sw_flow_mode, 4'hf);
        chk({rx_trigger, tx_trigger}, {7'd20, 7'd12});
        chk({rx_fcr, tx_fcr}, 2'b00);
        wr(12'h020, 8'h50);
        st;
        chk(tx_fcr, 1'b1);
        wr(12'h00c, 8'h00);
        rc(12'h020, 8'h00);
    endtask
    task automatic t_div;
        wr(12'h014, 8'h34);
        wr(12'h018, 8'h12);
        st;
        chk(baud, 16'h1234);
        wr(12'h000, 8'h10);
        wr(12'h014, 8'h99);
        st;
        chk(baud, 16'h1234);
        wr(12'h000, 8'h00);
    endtask
    // All sources at once, then cleared one by one from the top
    task automatic t_irq;
        wr(12'h008, 8'h01);
        wr(12'h000, 8'hef);
        @(posedge pclk);
        src_events <= '1;
        @(posedge pclk);
        src_events <= '0;
        st;
        chk(irq, 1'b1);
        for (int i = 0; i < 7; i++) begin
            rc(12'h004, {2'b11, codes[i]});
            wr(12'h030, 8'h40 >> i);
        end
        rc(12'h004, 8'hc1);
        st;
        chk(irq, 1'b0);
    endtask
    task automatic t_special(input logic [7:0] c, input logic [7:0] x);
        @(posedge pclk);
        rx_char <= c;
        rx_char_valid <= 1'b1;
        @(posedge pclk);
        rx_char_valid <= 1'b0;
        st;
        rc(12'h004, x);
        wr(12'h030, 8'h02);
    endtask
    task automatic t_cts(input logic [7:0] f, input logic c, input logic x);
        wr(12'h010, f);
        @(posedge pclk);
        cts_req_n <= c;
        st;
        chk(tx_allow, x);
    endtask
    task automatic t_rts;
        wr(12'h00c, 8'h06);
        wr(12'h01c, 8'h14);
        wr(12'h010, 8'h50);
        st;
        chk(rts_n, 1'b0);
        // Stimulus changes only on a rising edge, never after the settle delay
        @(posedge pclk);
        fill <= 1'b1;
        wait_rts(1'b1);
        chk({rts_n, rx_level >= 7'd16}, 2'b11);
        @(posedge pclk);
        fill <= 1'b0;
        drain <= 1'b1;
        wait_rts(1'b0);
        chk({rts_n, rx_level <= 7'd4}, 2'b01);
        @(posedge pclk);
        drain <= 1'b0;
    endtask

    task print_verdict;
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Hang guard well beyond the expected run
    initial begin
        #60000;
        error_cnt++;
        print_verdict;
    end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rc(12'h004, 8'h01);
        chk({rts_n, tx_allow, rx_fcr, tx_fcr}, 4'hf);
        t_gate;
        t_div;
        t_irq;
        wr(12'h028, 8'h13);
        wr(12'h010, 8'h30);
        t_special(8'h14, 8'hc1);
        t_special(8'h13, 8'hd0);
        t_cts(8'h90, 1'b1, 1'b0);
        t_cts(8'h90, 1'b0, 1'b1);
        t_cts(8'h10, 1'b1, 1'b1);
        t_cts(8'h10, 1'b0, 1'b1);
        t_rts;
        // Transmit FIFO is tied full here, so no space is left
        rc(12'h024, 8'h00);
        apb(1'b0, 12'h100, 8'h00);
        chk(e, 1'b1);
        print_verdict;
    end
endmodule
